// ==== mcu_int_pkg.sv ====
package mcu_int_pkg;

    // Register indices, byte address is four times the index
    localparam logic [7:0] OPT_IDX = 8'h1F;
    localparam logic [7:0] PIN_EN_IDX = 8'h1D;
    localparam logic [7:0] PIN_FLAG_IDX = 8'h1E;
    localparam logic [7:0] SEQ_STAT_IDX = 8'h20;
    localparam int ADDR_W = 12;

    // Option register fields and reset values
    localparam int TRIG_SEL_BIT = 1;
    localparam logic [7:0] OPT_RST = 8'h02;
    localparam logic [2:0] PIN_EN_RST = 3'h0;
    localparam logic [2:0] PIN_FLAG_RST = 3'h0;

    // Vector table, one entry per hardware source in priority order
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP = 16'hFFFC;
    localparam logic [15:0] VEC_IRQ = 16'hFFFA;
    localparam logic [15:0] VEC_TIMER = 16'hFFF8;
    localparam logic [15:0] VEC_SPI = 16'hFFF6;
    localparam logic [15:0] VEC_CALLER = 16'hFFF4;
    localparam logic [15:0] VEC_PIN_KEY = 16'hFFF2;
    localparam logic [15:0] VEC_CORE = 16'hFFF0;
    localparam int NSRC = 6;
    localparam int SRC_IRQ = 0;
    localparam int SRC_PIN_KEY = 4;
    localparam logic [NSRC*16-1:0] VEC_TABLE =
        {VEC_CORE, VEC_PIN_KEY, VEC_CALLER, VEC_SPI, VEC_TIMER, VEC_IRQ};

    typedef enum logic [1:0] {ST_RESET_VEC, ST_RUN, ST_STACK, ST_VECTOR} seq_state_t;

    // Instruction sequencer events, all one-cycle pulses except the levels trapAtEnd and retMask
    typedef struct packed {
        logic instrDone;
        logic trapAtEnd;
        logic trapFetched;
        logic stackDone;
        logic retDone;
        logic retMask;
        logic cliExec;
        logic seiExec;
    } cpu_evt_t;

    // Requests from on-chip peripherals, already gated by their enables
    typedef struct packed {
        logic coreTimer;
        logic keypad;
        logic caller;
        logic spi;
        logic timer;
    } periph_req_t;

endpackage : mcu_int_pkg

// ==== mcu_interrupt_sequencer.sv ====
// Operation
// RULE1 - Requests are only acted upon at an instruction boundary.
// RULE2 - Finish instruction, stack registers, set mask, then inspect pending sources.
// RULE3 - Highest vector address among pending sources is served first.
// RULE4 - Each source fetches its own two-byte vector near the top of memory.
// RULE5 - Return from handler restores the saved mask and resumes.
// RULE6 - Reset sets the mask and loads the reset vector.
// RULE7 - Software trap runs regardless of mask using its own vector.
// RULE8 - Trap follows requests pending at its fetch, precedes later ones.
// RULE9 - Mask set blocks all hardware sources except reset.
// RULE10 - Level mode: low level or falling edge requests, repeats while low.
// RULE11 - Level mode has no latch; short pulse under mask is lost.
// RULE12 - Edge mode: only falling edges request; held low does not repeat.
// RULE13 - Edge mode latches one edge; cleared by reset or vector fetch.
// RULE14 - External pulses must be spaced by handler time plus 21 cycles.
// RULE15 - Shared wired-AND line still low is the next request.
// RULE16 - Trigger select is option bit 1, set by reset, write-once.
// RULE17 - Port pins 0,1 falling edge; pin 2 both edges.
// RULE18 - Each port pin gated by its enable; shares pin/keypad vector.
// RULE19 - Port pin edge under mask is latched; held low never retriggers.
// RULE20 - Port pin flags clear only by reset or software writing 0.
// RULE21 - Software drives pins high before enabling their interrupts.
// RULE22 - Port pin enables sit in bits 2..0 of enable register.
// RULE23 - Port pin flags sit in bits 2..0, reset 0, write 0 clears.
// RULE24 - Shared-vector sources keep own flags, ORed into one request.
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module mcu_interrupt_sequencer (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mcu_int_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mcu_int_pkg::cpu_evt_t cpuEvt,
    input wire mcu_int_pkg::periph_req_t periphReq,
    input wire logic irqPinLow,
    input wire logic [2:0] portAPins,
    output logic stackReq,
    output logic vecLoad,
    output logic [15:0] vecAddr,
    output logic intMask,
    output logic [7:0] optionReg
);

    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        mcu_int_pkg::seq_state_t st;
        logic [3:0] syncA;
        logic [3:0] syncB;
        logic [3:0] syncC;
        logic [3:0] pinLvl;
        logic iMask;
        logic [7:0] opt;
        logic optWritten;
        logic [2:0] pinEn;
        logic [2:0] pinFlags;
        logic irqLatch;
        logic trapPend;
        logic hwBeforeTrap;
        logic [mcu_int_pkg::NSRC-1:0] takeSnap;
        logic stackReq;
        logic vecLoad;
        logic [15:0] vecAddr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;

    state_t cur_r;
    state_t cur_nxt;

    logic [3:0] fallEdge;
    logic [3:0] riseEdge;
    logic trigEdgeOnly;
    logic extReq;
    logic [2:0] pinEvt;
    logic [mcu_int_pkg::NSRC-1:0] hwReq;
    logic anyHw;
    logic apbAccess;
    logic [7:0] regIdx;
    logic [mcu_int_pkg::NSRC-1:0] selSet;
    logic [15:0] selVec;

    ////////////////////////////////////////////////////////////////////
    // Request decode
    always_comb begin
        fallEdge = 4'h0;
        riseEdge = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (cur_r.syncC[i] == cur_r.syncB[i]) begin
                fallEdge[i] = cur_r.pinLvl[i] && !cur_r.syncC[i];
                riseEdge[i] = !cur_r.pinLvl[i] && cur_r.syncC[i];
            end
        end
        trigEdgeOnly = cur_r.opt[mcu_int_pkg::TRIG_SEL_BIT]; // RULE16
        // Bit 3 is the dedicated pin, sampled as pin level (high = idle)
        if (trigEdgeOnly) begin
            extReq = cur_r.irqLatch; // RULE12 RULE13
        end else begin
            extReq = !cur_r.pinLvl[3]; // RULE10 RULE11 RULE15
        end
        pinEvt[0] = fallEdge[0] && cur_r.pinEn[0]; // RULE17 RULE18 RULE22
        pinEvt[1] = fallEdge[1] && cur_r.pinEn[1]; // RULE17 RULE18
        pinEvt[2] = (fallEdge[2] || riseEdge[2]) && cur_r.pinEn[2]; // RULE17 RULE18
        hwReq = {periphReq.coreTimer,
                 periphReq.keypad || (|cur_r.pinFlags), // RULE24
                 periphReq.caller, periphReq.spi, periphReq.timer, extReq};
        anyHw = |hwReq;
        // Lowest index is the highest vector
        selSet = hwReq | cur_r.takeSnap;
        selVec = mcu_int_pkg::VEC_CORE;
        for (int i = mcu_int_pkg::NSRC - 1; i >= 0; i--) begin
            if (selSet[i]) begin
                selVec = mcu_int_pkg::VEC_TABLE[i*16 +: 16]; // RULE3 RULE4
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        cur_nxt = cur_r;
        apbAccess = psel && penable && !cur_r.pready;
        regIdx = 8'(paddr[mcu_int_pkg::ADDR_W-1:2]);
        cur_nxt.syncA = {irqPinLow ? 1'b0 : 1'b1, portAPins};
        cur_nxt.syncB = cur_r.syncA;
        cur_nxt.syncC = cur_r.syncB;
        for (int i = 0; i < 4; i++) begin
            if (cur_r.syncC[i] == cur_r.syncB[i]) begin
                cur_nxt.pinLvl[i] = cur_r.syncC[i];
            end
        end
        cur_nxt.vecLoad = 1'b0;
        cur_nxt.pready = 1'b0;
        cur_nxt.pslverr = 1'b0;

        // Dedicated pin latch, set beats the clear at vector fetch
        if (cur_r.vecLoad && cur_r.vecAddr == mcu_int_pkg::VEC_IRQ) begin
            cur_nxt.irqLatch = 1'b0; // RULE13
        end
        if (!trigEdgeOnly) begin
            cur_nxt.irqLatch = 1'b0; // RULE11
        end else if (fallEdge[3]) begin
            cur_nxt.irqLatch = 1'b1; // RULE13
        end

        if (cpuEvt.trapFetched) begin
            cur_nxt.hwBeforeTrap = anyHw && !cur_r.iMask; // RULE8
        end

        if (cpuEvt.cliExec) begin
            cur_nxt.iMask = 1'b0;
        end
        if (cpuEvt.seiExec) begin
            cur_nxt.iMask = 1'b1;
        end
        if (cpuEvt.retDone) begin
            cur_nxt.iMask = cpuEvt.retMask; // RULE5
        end

        case (cur_r.st)
            mcu_int_pkg::ST_RESET_VEC: begin
                cur_nxt.vecLoad = 1'b1; // RULE6
                cur_nxt.vecAddr = mcu_int_pkg::VEC_RESET; // RULE6
                cur_nxt.st = mcu_int_pkg::ST_RUN;
            end
            mcu_int_pkg::ST_RUN: begin
                if (cpuEvt.instrDone) begin // RULE1
                    if (anyHw && !cur_r.iMask &&
                        (!cpuEvt.trapAtEnd || cur_r.hwBeforeTrap)) begin // RULE9 RULE8
                        cur_nxt.trapPend = 1'b0;
                        cur_nxt.takeSnap = hwReq;
                        cur_nxt.stackReq = 1'b1;
                        cur_nxt.st = mcu_int_pkg::ST_STACK;
                    end else if (cpuEvt.trapAtEnd) begin
                        cur_nxt.trapPend = 1'b1; // RULE7
                        cur_nxt.takeSnap = '0;
                        cur_nxt.stackReq = 1'b1;
                        cur_nxt.st = mcu_int_pkg::ST_STACK;
                    end
                end
            end
            mcu_int_pkg::ST_STACK: begin
                if (cpuEvt.stackDone) begin
                    cur_nxt.stackReq = 1'b0;
                    cur_nxt.iMask = 1'b1; // RULE2
                    cur_nxt.st = mcu_int_pkg::ST_VECTOR;
                end
            end
            mcu_int_pkg::ST_VECTOR: begin
                // Pending set examined now, after stacking, ORed with the takeSnap copy taken at the boundary
                cur_nxt.vecLoad = 1'b1; // RULE2
                cur_nxt.vecAddr = cur_r.trapPend ? mcu_int_pkg::VEC_TRAP : selVec; // RULE4 RULE7
                cur_nxt.trapPend = 1'b0;
                cur_nxt.hwBeforeTrap = 1'b0;
                cur_nxt.takeSnap = '0;
                cur_nxt.st = mcu_int_pkg::ST_RUN;
            end
            default: begin
                cur_nxt.st = mcu_int_pkg::ST_RUN;
            end
        endcase

        // APB slave, answers on the second access cycle
        cur_nxt.prdata = 32'h0;
        if (apbAccess) begin
            cur_nxt.pready = 1'b1;
            case (regIdx)
                mcu_int_pkg::OPT_IDX: begin
                    cur_nxt.prdata = {24'h0, cur_r.opt};
                    if (pwrite && !cur_r.optWritten) begin
                        cur_nxt.opt = pwdata[7:0]; // RULE16
                        cur_nxt.optWritten = 1'b1; // RULE16
                    end
                end
                mcu_int_pkg::PIN_EN_IDX: begin
                    cur_nxt.prdata = {29'h0, cur_r.pinEn};
                    if (pwrite) begin
                        cur_nxt.pinEn = pwdata[2:0]; // RULE22
                    end
                end
                mcu_int_pkg::PIN_FLAG_IDX: begin
                    cur_nxt.prdata = {29'h0, cur_r.pinFlags};
                    if (pwrite) begin
                        cur_nxt.pinFlags = cur_r.pinFlags & pwdata[2:0]; // RULE20 RULE23
                    end
                end
                mcu_int_pkg::SEQ_STAT_IDX: begin
                    cur_nxt.prdata = {24'h0, cur_r.pinLvl, extReq, cur_r.irqLatch,
                                      cur_r.trapPend, cur_r.iMask};
                end
                default: begin
                    cur_nxt.pslverr = 1'b1;
                end
            endcase
        end
        // Flag set wins over a simultaneous software clear
        cur_nxt.pinFlags = cur_nxt.pinFlags | pinEvt; // RULE19 RULE23
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cur_r <= '{st: mcu_int_pkg::ST_RESET_VEC, syncA: 4'hF, syncB: 4'hF,
                       syncC: 4'hF, pinLvl: 4'hF, iMask: 1'b1, // RULE6
                       opt: mcu_int_pkg::OPT_RST, optWritten: 1'b0,
                       pinEn: mcu_int_pkg::PIN_EN_RST,
                       pinFlags: mcu_int_pkg::PIN_FLAG_RST, irqLatch: 1'b0,
                       trapPend: 1'b0, hwBeforeTrap: 1'b0, takeSnap: '0,
                       stackReq: 1'b0, vecLoad: 1'b0,
                       vecAddr: mcu_int_pkg::VEC_RESET, prdata: 32'h0,
                       pready: 1'b0, pslverr: 1'b0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign prdata = cur_r.prdata;
    assign pready = cur_r.pready;
    assign pslverr = cur_r.pslverr;
    assign stackReq = cur_r.stackReq;
    assign vecLoad = cur_r.vecLoad;
    assign vecAddr = cur_r.vecAddr;
    assign intMask = cur_r.iMask;
    assign optionReg = cur_r.opt;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_stack_done;
        cur_r.stackReq && cpuEvt.stackDone;
    endsequence

    sequence s_vector_out;
        cur_r.vecLoad && cur_r.iMask;
    endsequence

    a_boundary_only: assert property ($rose(cur_r.stackReq) |-> $past(cpuEvt.instrDone)) // RULE1
        else $error("stacking began mid instruction");
    a_mask_then_vec: assert property (s_stack_done |=> cur_r.iMask ##1 s_vector_out) // RULE2
        else $error("mask not set before vector fetch");
    a_irq_top_prio: assert property (cur_r.st == mcu_int_pkg::ST_VECTOR && !cur_r.trapPend
            && hwReq[mcu_int_pkg::SRC_IRQ] |=> cur_r.vecAddr == mcu_int_pkg::VEC_IRQ) // RULE3
        else $error("external source not served first");
    a_ret_restore: assert property (cpuEvt.retDone && !cpuEvt.cliExec && !cpuEvt.seiExec
            && cur_r.st == mcu_int_pkg::ST_RUN |=> cur_r.iMask == $past(cpuEvt.retMask)) // RULE5
        else $error("mask not restored on return");
    a_reset_vector: assert property ($rose(nrst) |=> cur_r.vecLoad && cur_r.iMask
            && cur_r.vecAddr == mcu_int_pkg::VEC_RESET) // RULE6
        else $error("reset vector not loaded");
    a_trap_unmasked: assert property (cur_r.st == mcu_int_pkg::ST_RUN && cpuEvt.instrDone
            && cpuEvt.trapAtEnd |=> cur_r.stackReq) // RULE7
        else $error("software trap not taken");
    a_mask_blocks: assert property (cur_r.st == mcu_int_pkg::ST_RUN && cpuEvt.instrDone
            && cur_r.iMask && !cpuEvt.trapAtEnd |=> !cur_r.stackReq) // RULE9
        else $error("masked request taken");
    a_edge_no_level: assert property (trigEdgeOnly && !cur_r.irqLatch |-> !extReq) // RULE12
        else $error("edge mode request without edge");
    a_latch_cleared: assert property (cur_r.vecLoad && cur_r.vecAddr == mcu_int_pkg::VEC_IRQ
            && !fallEdge[3] |=> !cur_r.irqLatch) // RULE13
        else $error("edge latch survived vector fetch");
    a_opt_once: assert property (cur_r.optWritten |=> $stable(cur_r.opt)) // RULE16
        else $error("option register written twice");
    a_flag_sticky: assert property (!(apbAccess && pwrite && regIdx == mcu_int_pkg::PIN_FLAG_IDX)
            |=> (cur_r.pinFlags & $past(cur_r.pinFlags)) == $past(cur_r.pinFlags)) // RULE20
        else $error("pin flag cleared without write");
    a_flag_set: assert property (pinEvt[0] |=> cur_r.pinFlags[0]) // RULE18
        else $error("enabled pin edge missed");

endmodule : mcu_interrupt_sequencer

`default_nettype wire

// ==== cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module cpu_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic stackReq,
    input wire logic vecLoad,
    input wire logic [3:0] ctl,
    input wire logic retMask,
    input wire logic [3:0] stackDelay,
    output wire mcu_int_pkg::cpu_evt_t cpuEvt
);
    logic [1:0] phase_r;
    logic [3:0] sCnt_r;
    logic busy_r, trapPend_r, iDone_r, sDone_r;

    ////////////////////////////////////////////////////////////////////////////////
    // No instruction ends between stacking request and vector load
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            phase_r <= 2'h0;
            sCnt_r <= 4'h0;
            {busy_r, trapPend_r, iDone_r, sDone_r} <= 4'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
            iDone_r <= !busy_r && !stackReq && phase_r == 2'h3;
            busy_r <= stackReq || (busy_r && !vecLoad);
            if (ctl[3]) begin
                trapPend_r <= 1'h1;
            end else if (iDone_r) begin
                trapPend_r <= 1'h0;
            end
            sDone_r <= stackReq && !sDone_r && sCnt_r == stackDelay;
            sCnt_r <= (stackReq && !sDone_r) ? sCnt_r + 4'h1 : 4'h0;
        end
    end

    assign cpuEvt = '{instrDone: iDone_r, trapAtEnd: trapPend_r, trapFetched: ctl[3],
        stackDone: sDone_r, retDone: ctl[0], retMask: retMask, cliExec: ctl[2],
        seiExec: ctl[1]};
endmodule : cpu_model

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    localparam logic [3:0] TRAP = 4'h8;
    localparam logic [3:0] CLI = 4'h4;
    localparam logic [3:0] SEI = 4'h2;
    localparam logic [3:0] RET = 4'h1;
    localparam logic [7:0] OPT = mcu_int_pkg::OPT_IDX;
    localparam logic [7:0] FLG = mcu_int_pkg::PIN_FLAG_IDX;
    localparam logic [7:0] ENB = mcu_int_pkg::PIN_EN_IDX;
    logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [mcu_int_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    wire mcu_int_pkg::cpu_evt_t cpuEvt;
    mcu_int_pkg::periph_req_t periphReq;
    logic irqPinLow, stackReq, vecLoad, intMask, retMask;
    logic [2:0] portAPins;
    logic [3:0] ctl, stackDelay;
    logic [15:0] vecAddr, lastVec;
    logic [7:0] optionReg, vecCount;
    int nMismatch = 0;
    int nChecks = 0;

    mcu_interrupt_sequencer i_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpuEvt(cpuEvt), .periphReq(periphReq),
        .irqPinLow(irqPinLow), .portAPins(portAPins), .stackReq(stackReq), .vecLoad(vecLoad),
        .vecAddr(vecAddr), .intMask(intMask), .optionReg(optionReg));
    cpu_model i_cpu (.ref_clk(ref_clk), .nrst(nrst), .stackReq(stackReq), .vecLoad(vecLoad),
        .ctl(ctl), .retMask(retMask), .stackDelay(stackDelay), .cpuEvt(cpuEvt));

    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (vecLoad === 1'h1) begin
            lastVec <= vecAddr;
            vecCount <= vecCount + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (nMismatch == 0 && nChecks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        nChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic op(input logic [3:0] c, input logic m);
        ctl <= c;
        retMask <= m;
        @(posedge ref_clk);
        ctl <= 4'h0;
        @(posedge ref_clk);
    endtask : op

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int i;
        logic bad;
        i = 0;
        bad = !(idx inside {OPT, FLG, ENB, mcu_int_pkg::SEQ_STAT_IDX});
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'h1;
        do begin
            @(posedge ref_clk);
            i++;
        end while (pready !== 1'h1 && i < 50);
        chk({31'h0, pready}, 32'h1, "ready");
        if (!w && !bad) chk(prdata, {24'h0, d}, "read data");
        chk({31'h0, pslverr}, {31'h0, bad}, "error response");
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge ref_clk);
    endtask : apb

    task automatic wait_vec(input logic [15:0] exp);
        logic [7:0] n0;
        int i;
        n0 = vecCount;
        i = 0;
        while (vecCount === n0 && i < 300) begin
            @(posedge ref_clk);
            i++;
        end
        @(posedge ref_clk);
        chk({24'h0, 8'(vecCount - n0)}, 32'h1, "vector count");
        chk({16'h0, lastVec}, {16'h0, exp}, "vector");
        chk({31'h0, intMask}, 32'h1, "mask in handler");
    endtask : wait_vec

    task automatic no_vec;
        logic [7:0] n0;
        n0 = vecCount;
        repeat (40) @(posedge ref_clk);
        chk({24'h0, vecCount}, {24'h0, n0}, "unexpected vector");
    endtask : no_vec

    task automatic do_reset;
        logic [7:0] n0;
        nrst <= 1'h0;
        repeat (20) @(posedge ref_clk);
        n0 = vecCount;
        nrst <= 1'h1;
        repeat (3) @(posedge ref_clk);
        chk({24'h0, vecCount}, {24'h0, 8'(n0 + 8'h01)}, "reset load");
        chk({16'h0, lastVec}, 32'h0000FFFE, "reset vector");
        chk({31'h0, intMask}, 32'h1, "reset mask");
        chk({24'h0, optionReg}, {24'h0, mcu_int_pkg::OPT_RST}, "option reset");
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        nMismatch++;
        end_of_test();
    end

    initial begin
        ref_clk = 1'h0;
        nrst = 1'h0;
        {psel, penable, pwrite, irqPinLow, retMask} = 5'h00;
        paddr = '0;
        pwdata = 32'h0;
        periphReq = '0;
        portAPins = 3'h7;
        {ctl, stackDelay} = 8'h00;
        vecCount = 8'h00;
        lastVec = 16'h0000;
        do_reset();
        apb(1'h0, OPT, 8'h02);
        apb(1'h0, FLG, 8'h00);
        apb(1'h1, ENB, 8'h05);
        apb(1'h0, ENB, 8'h05);
        apb(1'h0, 8'h10, 8'h00);
        {periphReq.timer, periphReq.spi, periphReq.caller, periphReq.coreTimer} <= 4'hF;
        no_vec();
        op(TRAP, 1'h0);
        wait_vec(mcu_int_pkg::VEC_TRAP);
        op(RET, 1'h1);
        chk({31'h0, intMask}, 32'h1, "restored mask");
        stackDelay <= 4'h9;
        op(CLI, 1'h0);
        wait_vec(mcu_int_pkg::VEC_TIMER);
        periphReq.timer <= 1'h0;
        op(RET, 1'h0);
        wait_vec(mcu_int_pkg::VEC_SPI);
        periphReq.spi <= 1'h0;
        op(RET, 1'h0);
        wait_vec(mcu_int_pkg::VEC_CALLER);
        periphReq.caller <= 1'h0;
        op(RET, 1'h0);
        wait_vec(mcu_int_pkg::VEC_CORE);
        periphReq.coreTimer <= 1'h0;
        stackDelay <= 4'h0;
        op(RET, 1'h0);
        op(TRAP, 1'h0);
        periphReq.timer <= 1'h1;
        wait_vec(mcu_int_pkg::VEC_TRAP);
        op(RET, 1'h0);
        wait_vec(mcu_int_pkg::VEC_TIMER);
        periphReq.timer <= 1'h0;
        op(RET, 1'h0);
        // Pin 1 is disabled, pins 0 and 2 fall under mask
        op(SEI, 1'h0);
        portAPins <= 3'h0;
        repeat (8) @(posedge ref_clk);
        apb(1'h0, FLG, 8'h05);
        op(CLI, 1'h0);
        wait_vec(mcu_int_pkg::VEC_PIN_KEY);
        op(RET, 1'h0);
        wait_vec(mcu_int_pkg::VEC_PIN_KEY);
        apb(1'h1, FLG, 8'h00);
        apb(1'h0, FLG, 8'h00);
        op(RET, 1'h0);
        no_vec();
        portAPins <= 3'h7;
        wait_vec(mcu_int_pkg::VEC_PIN_KEY);
        apb(1'h0, FLG, 8'h04);
        apb(1'h1, FLG, 8'h00);
        periphReq.keypad <= 1'h1;
        op(RET, 1'h0);
        wait_vec(mcu_int_pkg::VEC_PIN_KEY);
        periphReq.keypad <= 1'h0;
        apb(1'h0, FLG, 8'h00);
        op(SEI, 1'h0);
        op(RET, 1'h1);
        irqPinLow <= 1'h1;
        repeat (8) @(posedge ref_clk);
        op(CLI, 1'h0);
        wait_vec(mcu_int_pkg::VEC_IRQ);
        op(RET, 1'h0);
        no_vec();
        irqPinLow <= 1'h0;
        repeat (8) @(posedge ref_clk);
        apb(1'h1, OPT, 8'h00);
        apb(1'h1, OPT, 8'h02);
        apb(1'h0, OPT, 8'h00);
        irqPinLow <= 1'h1;
        wait_vec(mcu_int_pkg::VEC_IRQ);
        op(RET, 1'h0);
        wait_vec(mcu_int_pkg::VEC_IRQ);
        irqPinLow <= 1'h0;
        repeat (30) @(posedge ref_clk);
        op(RET, 1'h0);
        no_vec();
        op(SEI, 1'h0);
        irqPinLow <= 1'h1;
        repeat (6) @(posedge ref_clk);
        irqPinLow <= 1'h0;
        repeat (8) @(posedge ref_clk);
        op(CLI, 1'h0);
        no_vec();
        do_reset();
        apb(1'h0, ENB, 8'h00);
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
